// ### isp_consts.svh
// offsets, field positions, reset values and vector numbers of the interrupt source block
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH
`define ISP_OFF_SYS 8'h00
`define ISP_OFF_SENSE 8'h04
`define ISP_OFF_EN 8'h08
`define ISP_OFF_FLAG 8'h0c
`define ISP_OFF_PRA 8'h10
`define ISP_OFF_PRB 8'h14
`define ISP_OFF_STAT 8'h18
`define ISP_SYS_EDGE 0
`define ISP_SYS_UE 1
`define ISP_STAT_ACC 6
`define ISP_STAT_VALID 7
`define ISP_RST_REG 8'h00
`define ISP_RST_UE 1'b1
`define ISP_RST_PIN 3'h7
`define ISP_VEC_NMI 6'h07
`define ISP_VEC_PIN0 6'h0c
`define ISP_VEC_PIN7 6'h13
`define ISP_VEC_WDT 6'h14
`define ISP_VEC_RFSH 6'h15
`define ISP_VEC_TMR0 6'h18
`define ISP_VEC_DMA0 6'h2c
`define ISP_VEC_SER0 6'h34
`define ISP_VEC_ADC 6'h3c
`define ISP_RSV_MASK 64'he000_0888_88c0_0f7f
`define ISP_NSRC 34
`define ISP_SRC_TMR0 2
`define ISP_SRC_DMA0 17
`define ISP_SRC_SER0 25
`define ISP_SRC_ADC 33
`define ISP_DMA_CAPABLE 34'h1_fe01_fffc
`define ISP_NPIN 8
`endif

// ### isp_pkg.sv
// types shared by the interrupt source block
package isp_pkg;
  typedef struct packed {
    logic int_mask;
    logic second_mask_bit;
    logic ack;
    logic [5:0] ack_vec;
  } isp_cpu_in_s;
  typedef struct packed {
    logic valid;
    logic accept;
    logic [5:0] vec;
    logic [15:0] vaddr;
  } isp_cpu_out_s;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } isp_pin_state_s;
  typedef struct packed {
    logic nm_edge;
    logic ue;
    logic [7:0] sense;
    logic [7:0] en;
    logic [7:0] flag;
    logic [7:0] pa;
    logic [7:0] pb;
    logic nmi_pend;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [7:0] rdata;
    isp_cpu_out_s cpu;
    logic wake;
  } isp_state_s;
endpackage

// ### isp_pin_sense.sv
// pin synchroniser with edge detection
`timescale 1ns/1ps
`include "isp_consts.svh"
module isp_pin_sense import isp_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // asynchronous pin
  input wire logic pin,
  // synchronised level and edges
  output logic lvl,
  output logic rise,
  output logic fall
);
  isp_pin_state_s s_q;
  isp_pin_state_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  // resets to idle high so a quiet pin gives no false edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= `ISP_RST_PIN;
    end else begin
      s_q <= s_d;
    end
  end

  assign lvl = s_q.s2;
  assign rise = s_q.s2 & ~s_q.s3;
  assign fall = ~s_q.s2 & s_q.s3;
endmodule

// ### isp_ctrl.sv
// interrupt source collection, priority resolution and vector generation
//
// Functional notes
// - nonmaskable request ranks highest and is accepted regardless of cpu mask bits
// - nonmaskable request caught on rising or falling edge per edge-select bit
// - nonmaskable request reports vector 7
// - each request pin requests while low or on falling edge, per sense bit
// - pin requests gated by enable; four priority bits cover pins 0,1,2-3,4-7
// - per-pin status flag, software clears it by writing 0
// - pins 0 to 7 use vectors 12 to 19 in order
// - pin activity is seen whatever the pin direction
// - only nonmaskable request and pins 0 to 2 wake from software standby
// - 34 internal requests arrive already qualified by unit flag and enable
// - timer or serial requests routed to dma are not forwarded as interrupts
// - equal priority level: smaller vector number wins
// - priority bits raise any source but nonmaskable and refresh; reset gives default order
// - vector table address is four times the vector number, low 16 bits
// - timer channels 0-4 use vector groups of four from 24, one priority bit each
// - serial channels use vectors 52-55 and 56-59, one priority bit each
// - watchdog 20, refresh 21 without priority bit, dma ends 44-51, a/d end 60
// - pin flag sets while low in level mode, on high-to-low in edge mode
// - priority bit 1 means high level, 0 low level, all reset to 0
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "isp_consts.svh"
module isp_ctrl import isp_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // external request pins
  input wire logic nonmask_pin,
  input wire logic [7:0] irq_pin_n,
  // on-chip units, indexed by source number
  input wire logic [33:0] int_req,
  input wire logic [33:0] int_dma,
  // cpu core
  input wire isp_cpu_in_s cpu_in,
  output isp_cpu_out_s cpu_out,
  // software standby
  input wire logic standby,
  output logic wake
);
  isp_state_s s_q;
  isp_state_s s_d;

  logic [8:0] pin_lvl;
  logic [8:0] pin_rise;
  logic [8:0] pin_fall;
  logic nmi_evt;
  logic [7:0] pin_set;
  logic [7:0] lvl_set;
  logic [7:0] edge_set;
  logic [7:0] ack_clr;
  logic wr_flag;
  logic [63:0] req64;
  logic [63:0] lvl64;
  logic [63:0] dma64;
  logic [63:0] cand;
  logic hi_any;
  logic [5:0] win;
  logic wake_src;
  logic [31:0] sel_addr;
  // a literal cannot be bit-selected, so the dma route map is held as a constant vector
  localparam logic [33:0] dma_capable = `ISP_DMA_CAPABLE;

  // vector number of internal source i
  function automatic logic [5:0] src_vec(input int i);
    int v;
    if (i == 0) begin
      v = int'(`ISP_VEC_WDT);
    end else if (i == 1) begin
      v = int'(`ISP_VEC_RFSH);
    end else if (i < `ISP_SRC_DMA0) begin
      v = int'(`ISP_VEC_TMR0) + 4 * ((i - `ISP_SRC_TMR0) / 3) + (i - `ISP_SRC_TMR0) % 3;
    end else if (i < `ISP_SRC_SER0) begin
      v = int'(`ISP_VEC_DMA0) + (i - `ISP_SRC_DMA0);
    end else if (i < `ISP_SRC_ADC) begin
      v = int'(`ISP_VEC_SER0) + (i - `ISP_SRC_SER0);
    end else begin
      v = int'(`ISP_VEC_ADC);
    end
    return 6'(v);
  endfunction

  // priority level of a vector number
  function automatic logic prio_of(input int v, input logic [7:0] pa, input logic [7:0] pb);
    logic p;
    p = 1'b0;
    if (v == int'(`ISP_VEC_NMI)) begin
      p = 1'b1;
    end else if (v == 12) begin
      p = pa[7];
    end else if (v == 13) begin
      p = pa[6];
    end else if (v >= 14 && v <= 15) begin
      p = pa[5];
    end else if (v >= 16 && v <= 19) begin
      p = pa[4];
    end else if (v == 20) begin
      p = pa[3];
    end else if (v >= 24 && v <= 26) begin
      p = pa[2];
    end else if (v >= 28 && v <= 30) begin
      p = pa[1];
    end else if (v >= 32 && v <= 34) begin
      p = pa[0];
    end else if (v >= 36 && v <= 38) begin
      p = pb[7];
    end else if (v >= 40 && v <= 42) begin
      p = pb[6];
    end else if (v >= 44 && v <= 47) begin
      p = pb[5];
    end else if (v >= 48 && v <= 51) begin
      p = pb[4];
    end else if (v >= 52 && v <= 55) begin
      p = pb[3];
    end else if (v >= 56 && v <= 59) begin
      p = pb[2];
    end else if (v == int'(`ISP_VEC_ADC)) begin
      p = pb[1];
    end
    return p;
  endfunction

  // one-hot pin select for a pin vector, zero otherwise
  function automatic logic [7:0] pin_sel(input logic [5:0] v);
    logic [7:0] m;
    m = 8'h00;
    if (v >= `ISP_VEC_PIN0 && v <= `ISP_VEC_PIN7) begin
      m = 8'h01 << 3'(v - `ISP_VEC_PIN0);
    end
    return m;
  endfunction

  // request pins carry no direction input, so an output-driven level is seen too
  genvar g;
  generate
    for (g = 0; g <= `ISP_NPIN; g++) begin : g_pin
      logic pin_in;
      // the last slot carries the nonmaskable pin, so no out-of-range pin index is formed
      if (g == `ISP_NPIN) begin : g_nmi
        assign pin_in = nonmask_pin;
      end else begin : g_irq
        assign pin_in = irq_pin_n[g];
      end
      isp_pin_sense i_isp_pin_sense (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(pin_in),
        .lvl(pin_lvl[g]),
        .rise(pin_rise[g]),
        .fall(pin_fall[g])
      );
    end
  endgenerate

  assign nmi_evt = s_q.nm_edge ? pin_rise[`ISP_NPIN] : pin_fall[`ISP_NPIN];
  assign lvl_set = ~s_q.sense & ~pin_lvl[7:0];
  assign edge_set = s_q.sense & pin_fall[7:0];
  assign pin_set = lvl_set | edge_set;
  assign wr_flag = s_q.ph_valid & s_q.ph_write & (s_q.ph_addr == `ISP_OFF_FLAG);
  // edge-mode flags are consumed by the exception; level-mode flags stay set until software writes 0
  assign ack_clr = cpu_in.ack ? (pin_sel(cpu_in.ack_vec) & s_q.sense) : 8'h00;
  assign wake_src = nmi_evt | (|(pin_set[2:0] & s_q.en[2:0]));
  assign sel_addr = haddr;

  // request, level and dma-route maps indexed by vector number
  always_comb begin
    req64 = 64'h0;
    dma64 = 64'h0;
    lvl64 = 64'h0;
    req64[`ISP_VEC_NMI] = s_q.nmi_pend;
    for (int n = 0; n < `ISP_NPIN; n++) begin
      req64[int'(`ISP_VEC_PIN0) + n] = s_q.flag[n] & s_q.en[n];
    end
    for (int i = 0; i < `ISP_NSRC; i++) begin
      req64[src_vec(i)] = int_req[i] & ~(int_dma[i] & dma_capable[i]);
      dma64[src_vec(i)] = int_dma[i] & dma_capable[i];
    end
    req64 = req64 & ~`ISP_RSV_MASK;
    for (int v = 0; v < 64; v++) begin
      lvl64[v] = prio_of(v, s_q.pa, s_q.pb);
    end
    hi_any = |(req64 & lvl64);
    cand = hi_any ? (req64 & lvl64) : req64;
    win = 6'h00;
    for (int v = 63; v >= 0; v--) begin
      if (cand[v]) begin
        win = 6'(v);
      end
    end
  end

  always_comb begin
    s_d = s_q;
    // data phase of a write
    if (s_q.ph_valid && s_q.ph_write) begin
      if (s_q.ph_addr == `ISP_OFF_SYS) begin
        s_d.nm_edge = hwdata[`ISP_SYS_EDGE];
        s_d.ue = hwdata[`ISP_SYS_UE];
      end else if (s_q.ph_addr == `ISP_OFF_SENSE) begin
        s_d.sense = hwdata[7:0];
      end else if (s_q.ph_addr == `ISP_OFF_EN) begin
        s_d.en = hwdata[7:0];
      end else if (s_q.ph_addr == `ISP_OFF_FLAG) begin
        s_d.flag = s_q.flag & hwdata[7:0];
      end else if (s_q.ph_addr == `ISP_OFF_PRA) begin
        s_d.pa = hwdata[7:0];
      end else if (s_q.ph_addr == `ISP_OFF_PRB) begin
        s_d.pb = hwdata[7:0];
      end
    end
    if (cpu_in.ack && cpu_in.ack_vec == `ISP_VEC_NMI) begin
      s_d.nmi_pend = 1'b0;
    end
    s_d.flag = s_d.flag & ~ack_clr;
    // new events win over any clear in the same cycle
    s_d.flag = s_d.flag | pin_set;
    if (nmi_evt) begin
      s_d.nmi_pend = 1'b1;
    end
    // address phase; read data taken from the updated state, status register from the current cpu outputs
    s_d.ph_valid = hsel & hready & htrans[1];
    s_d.ph_write = hwrite;
    s_d.ph_addr = sel_addr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (sel_addr[7:0] == `ISP_OFF_SYS) begin
        s_d.rdata = 8'h00;
        s_d.rdata[`ISP_SYS_EDGE] = s_d.nm_edge;
        s_d.rdata[`ISP_SYS_UE] = s_d.ue;
      end else if (sel_addr[7:0] == `ISP_OFF_SENSE) begin
        s_d.rdata = s_d.sense;
      end else if (sel_addr[7:0] == `ISP_OFF_EN) begin
        s_d.rdata = s_d.en;
      end else if (sel_addr[7:0] == `ISP_OFF_FLAG) begin
        s_d.rdata = s_d.flag;
      end else if (sel_addr[7:0] == `ISP_OFF_PRA) begin
        s_d.rdata = s_d.pa;
      end else if (sel_addr[7:0] == `ISP_OFF_PRB) begin
        s_d.rdata = s_d.pb;
      end else if (sel_addr[7:0] == `ISP_OFF_STAT) begin
        s_d.rdata = {s_q.cpu.valid, s_q.cpu.accept, s_q.cpu.vec};
      end else begin
        s_d.rdata = 8'h00;
      end
    end
    // presented vector; accept follows the cpu mask bits
    s_d.cpu.valid = |cand;
    s_d.cpu.vec = win;
    s_d.cpu.vaddr = {8'h00, win, 2'b00};
    s_d.cpu.accept = (|cand) && (cand[`ISP_VEC_NMI] || !cpu_in.int_mask ||
      (!s_q.ue && !cpu_in.second_mask_bit && hi_any));
    s_d.wake = standby & wake_src;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ue <= `ISP_RST_UE;
    end else begin
      s_q <= s_d;
    end
  end

  // zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, s_q.rdata};
  assign cpu_out = s_q.cpu;
  assign wake = s_q.wake;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_NMI_VEC:
    assert property (s_q.nmi_pend |=> s_q.cpu.valid && s_q.cpu.vec == `ISP_VEC_NMI)
      else $error("pending nonmaskable request not presented as vector 7");
  AST_NMI_ACC:
    assert property (s_q.nmi_pend |=> s_q.cpu.accept)
      else $error("nonmaskable request not accepted");
  AST_NMI_EDGE:
    assert property ((pin_rise[`ISP_NPIN] && s_q.nm_edge) || (pin_fall[`ISP_NPIN] && !s_q.nm_edge)
      |=> s_q.nmi_pend)
      else $error("selected nonmaskable edge missed");
  AST_LVL_SET:
    assert property (1'b1 |=> (s_q.flag & $past(lvl_set)) == $past(lvl_set))
      else $error("level mode flag not set while pin low");
  AST_EDGE_SET:
    assert property (1'b1 |=> (s_q.flag & $past(edge_set)) == $past(edge_set))
      else $error("edge mode flag not set on falling edge");
  AST_CLR_W0:
    assert property (wr_flag && pin_set == 8'h00 && !cpu_in.ack
      |=> s_q.flag == ($past(s_q.flag) & $past(hwdata[7:0])))
      else $error("flag write did not clear exactly the zero bits");
  AST_PIN_VEC:
    assert property (s_q.cpu.valid && pin_sel(s_q.cpu.vec) != 8'h00
      |-> (pin_sel(s_q.cpu.vec) & $past(s_q.en) & $past(s_q.flag)) != 8'h00)
      else $error("pin vector presented without enabled flag");
  AST_ORDER:
    assert property (s_q.cpu.valid |-> ((($past(cand) >> s_q.cpu.vec) & 64'h1) == 64'h1) &&
      (($past(cand) & ((64'h1 << s_q.cpu.vec) - 64'h1)) == 64'h0))
      else $error("presented vector is not the smallest candidate");
  AST_HIGH:
    assert property (s_q.cpu.valid && $past(hi_any) |-> (($past(lvl64) >> s_q.cpu.vec) & 64'h1) == 64'h1)
      else $error("low level source beat a pending high level source");
  AST_RSV:
    assert property (s_q.cpu.valid |-> ((`ISP_RSV_MASK >> s_q.cpu.vec) & 64'h1) == 64'h0)
      else $error("reserved vector presented");
  AST_DMA:
    assert property (s_q.cpu.valid |-> (($past(dma64) >> s_q.cpu.vec) & 64'h1) == 64'h0)
      else $error("dma routed request forwarded as interrupt");
  AST_VADDR:
    assert property (s_q.cpu.valid |-> s_q.cpu.vaddr[15:2] == 14'(s_q.cpu.vec) && s_q.cpu.vaddr[1:0] == 2'b00)
      else $error("vector address is not four times the vector");
  AST_WAKE:
    assert property (s_q.wake |-> $past(standby) && $past(wake_src))
      else $error("wake from a source not allowed to wake");
  AST_MASK_ACC:
    assert property (s_q.cpu.accept && s_q.cpu.vec != `ISP_VEC_NMI |-> !$past(cpu_in.int_mask) ||
      (!$past(s_q.ue) && !$past(cpu_in.second_mask_bit) && $past(hi_any)))
      else $error("masked request accepted");

  COV_NMI: cover property (s_q.cpu.valid && s_q.cpu.vec == `ISP_VEC_NMI);
  COV_PIN: cover property (s_q.cpu.valid && s_q.cpu.vec == `ISP_VEC_PIN7);
  COV_ADC_HI: cover property (s_q.cpu.valid && s_q.cpu.vec == `ISP_VEC_ADC && s_q.pb[1]);
  COV_WAKE: cover property (s_q.wake);
  COV_UE0_ACC: cover property (s_q.cpu.accept && !s_q.ue && cpu_in.int_mask);
endmodule

// ### isp_cpu_model.sv
// cpu core stand-in that acknowledges accepted vectors
`timescale 1ns/1ps
module isp_cpu_model import isp_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench controls
  input wire logic mask,
  input wire logic auto_ack,
  input wire logic ui_open,
  // controller side
  input wire isp_cpu_out_s cpu_out,
  output isp_cpu_in_s cpu_in
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_in <= '0;
    end else begin
      // ui_open leaves the second mask bit clear so high level requests can pass a set mask
      cpu_in.int_mask <= mask;
      cpu_in.second_mask_bit <= mask & ~ui_open;
      // ack is a one-cycle pulse, never on two cycles running, so a vector can see two; never on a refused one
      cpu_in.ack <= auto_ack && cpu_out.valid && cpu_out.accept && !cpu_in.ack;
      cpu_in.ack_vec <= cpu_out.vec;
    end
  end
endmodule

// ### interrupt_source_priority_vectors_test.sv
// self-checking bench for the interrupt source block
`timescale 1ns/1ps
`include "isp_consts.svh"
module interrupt_source_priority_vectors_test import isp_pkg::*; ;
  // nonmaskable pin idles high to match the falling-edge default and the synchroniser reset
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, nonmask_pin = 1;
  logic mask = 0, ui_open = 0, auto_ack = 0, standby = 0, wake;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  // request pins are driven only as plain inputs, never shared with other functions
  logic [7:0] irq_pin_n = 8'hff;
  logic [33:0] int_req = '0, int_dma = '0;
  isp_cpu_in_s cpu_in;
  isp_cpu_out_s cpu_out;
  int fail_count = 0, checks_done = 0;
  int wake_count = 0, wake_base = 0;
  int src[9] = '{2, 3, 4, 5, 16, 17, 24, 25, 32};
  int vec[9] = '{24, 25, 26, 28, 42, 44, 51, 52, 59};
  assign hready = hreadyout;
  isp_ctrl i_isp_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .nonmask_pin(nonmask_pin), .irq_pin_n(irq_pin_n),
    .int_req(int_req), .int_dma(int_dma), .cpu_in(cpu_in), .cpu_out(cpu_out), .standby(standby),
    .wake(wake));
  isp_cpu_model i_isp_cpu_model (.hclk(hclk), .hresetn(hresetn), .mask(mask), .auto_ack(auto_ack),
    .ui_open(ui_open), .cpu_out(cpu_out), .cpu_in(cpu_in));
  initial begin
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (wake === 1'b1) begin
      wake_count <= wake_count + 1;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // waits for a request to settle, then checks number and table address
  task automatic expect_vec(input logic [5:0] v);
    repeat (6) @(posedge hclk);
    chk("valid", 32'h1, {31'h0, cpu_out.valid});
    chk("vector", {26'h0, v}, {26'h0, cpu_out.vec});
    chk("vaddr", {16'h0, 8'h0, v, 2'b00}, {16'h0, cpu_out.vaddr});
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("sys", `ISP_OFF_SYS, 32'h2);
    for (int o = 4; o <= 28; o += 4) rd_chk("reg", o[7:0], 32'h0);
    wr(`ISP_OFF_SENSE, 32'h01);
    wr(`ISP_OFF_EN, 32'h01);
    irq_pin_n[0] <= 1'b0;
    expect_vec(`ISP_VEC_PIN0);
    rd_chk("flag", `ISP_OFF_FLAG, 32'h1);
    auto_ack <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("valid", 32'h0, {31'h0, cpu_out.valid});
    auto_ack <= 1'b0;
    irq_pin_n[0] <= 1'b1;
    // level mode: pins 0 and 3 together
    wr(`ISP_OFF_SENSE, 32'h00);
    wr(`ISP_OFF_EN, 32'h09);
    irq_pin_n <= 8'hf6;
    expect_vec(`ISP_VEC_PIN0);
    wr(`ISP_OFF_PRA, 32'h20);
    expect_vec(6'h0f);
    wr(`ISP_OFF_FLAG, 32'h00);
    rd_chk("flag", `ISP_OFF_FLAG, 32'h09);
    irq_pin_n <= 8'hff;
    repeat (4) @(posedge hclk);
    wr(`ISP_OFF_FLAG, 32'h00);
    rd_chk("flag", `ISP_OFF_FLAG, 32'h00);
    wr(`ISP_OFF_PRA, 32'h00);
    int_req <= 34'h1 | (34'h1 << 33);
    expect_vec(`ISP_VEC_WDT);
    wr(`ISP_OFF_PRB, 32'h02);
    expect_vec(`ISP_VEC_ADC);
    wr(`ISP_OFF_PRB, 32'h00);
    int_req <= 34'h2;
    expect_vec(`ISP_VEC_RFSH);
    int_req <= 34'h4;
    int_dma <= 34'h4;
    repeat (6) @(posedge hclk);
    chk("valid", 32'h0, {31'h0, cpu_out.valid});
    int_dma <= '0;
    for (int i = 0; i < 9; i++) begin
      int_req <= 34'h1 << src[i];
      expect_vec(vec[i][5:0]);
    end
    int_req <= '0;
    // masked pin request waits while the nonmaskable one gets through
    mask <= 1'b1;
    irq_pin_n[0] <= 1'b0;
    expect_vec(`ISP_VEC_PIN0);
    chk("accept", 32'h0, {31'h0, cpu_out.accept});
    wr(`ISP_OFF_SYS, 32'h03);
    // falling edge must be ignored while the rising edge is selected
    nonmask_pin <= 1'b0;
    expect_vec(`ISP_VEC_PIN0);
    nonmask_pin <= 1'b1;
    expect_vec(`ISP_VEC_NMI);
    chk("accept", 32'h1, {31'h0, cpu_out.accept});
    auto_ack <= 1'b1;
    expect_vec(`ISP_VEC_PIN0);
    auto_ack <= 1'b0;
    mask <= 1'b0;
    irq_pin_n[0] <= 1'b1;
    wr(`ISP_OFF_FLAG, 32'h00);
    // only low-numbered pins may wake from standby
    standby <= 1'b1;
    wr(`ISP_OFF_EN, 32'h22);
    wake_base = wake_count;
    irq_pin_n[5] <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("wake", 32'h0, {31'h0, wake_count != wake_base});
    irq_pin_n[1] <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("wake", 32'h1, {31'h0, wake_count != wake_base});
    // second mask bit clear: only high level requests pass the set mask
    standby <= 1'b0;
    mask <= 1'b1;
    ui_open <= 1'b1;
    wr(`ISP_OFF_SYS, 32'h00);
    expect_vec(6'h0d);
    chk("accept", 32'h0, {31'h0, cpu_out.accept});
    wr(`ISP_OFF_PRA, 32'h40);
    expect_vec(6'h0d);
    chk("accept", 32'h1, {31'h0, cpu_out.accept});
    // falling edge selected: the idle-high nonmaskable pin now drops
    nonmask_pin <= 1'b0;
    expect_vec(`ISP_VEC_NMI);
    chk("accept", 32'h1, {31'h0, cpu_out.accept});
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    report_and_stop();
  end
endmodule
